// file: pid_pkg.sv
// Constants shared by the PID process-control block
package pid_pkg;
  // Clock and sampling
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_US = 1000;
  localparam int MS_PER_S = 1000;
  // Setting value that switches a function off
  localparam logic [15:0] CODE_OFF = 16'h270f;
  // Action select codes: first is reverse, second forward
  localparam logic [15:0] ACT_REV = 16'h0014;
  localparam logic [15:0] ACT_FWD = 16'h0015;
  // Input function code of the PID select input
  localparam logic [15:0] IN_PIDSEL = 16'h000e;
  // Output function codes
  localparam logic [15:0] FN_LOWER = 16'h000e;
  localparam logic [15:0] FN_UPPER = 16'h000f;
  localparam logic [15:0] FN_DIR = 16'h0010;
  localparam logic [15:0] FN_ACTIVE = 16'h002f;
  localparam logic [15:0] FN_SLEEP = 16'h0046;
  localparam logic [15:0] FN_NEG = 16'h0064;
  // Register indexes, byte address is four times the index
  localparam logic [4:0] IX_ACTION = 5'h00;
  localparam logic [4:0] IX_PBAND = 5'h01;
  localparam logic [4:0] IX_ITIME = 5'h02;
  localparam logic [4:0] IX_UPPER = 5'h03;
  localparam logic [4:0] IX_LOWER = 5'h04;
  localparam logic [4:0] IX_SETPT = 5'h05;
  localparam logic [4:0] IX_DTIME = 5'h06;
  localparam logic [4:0] IX_AIN = 5'h07;
  localparam logic [4:0] IX_MRANGE = 5'h08;
  localparam logic [4:0] IX_INFUNC0 = 5'h09;
  localparam int NUM_INFUNC = 5;
  localparam logic [4:0] IX_OUTA = 5'h0e;
  localparam logic [4:0] IX_OUTB = 5'h0f;
  localparam logic [4:0] IX_THERM = 5'h10;
  localparam logic [4:0] IX_INTRT = 5'h11;
  localparam logic [4:0] IX_INTRL = 5'h12;
  localparam logic [4:0] IX_INTRC = 5'h13;
  localparam int NUM_CFG = 20;
  localparam logic [4:0] IX_STATUS = 5'h14;
  localparam logic [4:0] IX_FREQ = 5'h15;
  localparam logic [4:0] IX_PV = 5'h16;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_PBAND = 16'h03e8;
  localparam logic [15:0] RST_ITIME = 16'h000a;
  localparam logic [15:0] RST_AIN = 16'h0001;
  localparam logic [15:0] RST_INTRC = 16'h03e8;
  // Status bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_UPPER = 1;
  localparam int ST_LOWER = 2;
  localparam int ST_DIR = 3;
  localparam int ST_SLEEP = 4;
  // Percent scale in 0.1 % and analog scaling
  localparam int PCT_FULL = 1000;
  localparam int I_FRAC = 10;
  localparam logic [11:0] ADC_4MA = 12'h333;
  localparam logic [15:0] MUL_10V = 16'h03e8;
  localparam logic [15:0] MUL_5V = 16'h07d0;
  localparam logic [15:0] MUL_4MA = 16'h04e2;
  // Controller mode
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_RUN = 3'b010,
    MODE_SLEEP = 3'b100
  } pid_mode_t;
endpackage

// file: pid_process_control.sv
// PID process controller with Avalon-MM settings and status
//
// Operation
// - PID runs only with action select at one of two enable codes.
// - With select input assigned, PID runs only while that input is on.
// - Without an assigned select input, action select alone enables PID.
// - Action select zero or an assigned select input off gives normal frequency control.
// - Reverse sense: positive deviation raises frequency, negative lowers it.
// - Forward sense: negative deviation raises frequency, positive lowers it.
// - Manipulated value is sum of proportional, integral, differential parts.
// - Set point from terminal 2 when setting is off code, else stored.
// - Terminal 2 spans 5V or 10V per analog input select.
// - Terminal 4 spans 4-20mA, 5V or 10V per range select.
// - Upper flag when enabled, limit set and process value above it.
// - Lower flag when enabled, limit set and process value below it.
// - Direction output high for forward rotation, low otherwise.
// - Active output on while PID control is performed.
// - Sleep output on while output interruption is in effect.
// - Output function codes from 100 upward drive negative logic.
// - Thermistor level set blocks terminal 2 as set point.
// - Gain, time and set point settings writable at any time.
// - Off code disables a term or a limit output.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pid_process_control
  import pid_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_US * CLK_MHZ,
  parameter int FREQ_MAX = 5000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog inputs, 12-bit codes
  input wire logic [11:0] term2Code,
  input wire logic [11:0] term4Code,
  // Drive context
  input wire logic pidSelectInput,
  input wire logic forwardIndication,
  input wire logic reverseIndication,
  input wire logic [15:0] normalFreq,
  // Command and status terminals
  output logic [15:0] freqCmd,
  output logic termOutA,
  output logic termOutB
);

  localparam int TW = $clog2(SAMPLE_CYC);

  // Reset value of a settings word
  function automatic logic [15:0] rstVal(input int ix);
    case (ix)
      IX_PBAND: rstVal = RST_PBAND;
      IX_ITIME: rstVal = RST_ITIME;
      IX_UPPER, IX_LOWER, IX_SETPT, IX_DTIME: rstVal = CODE_OFF;
      IX_THERM, IX_INTRT: rstVal = CODE_OFF;
      IX_AIN: rstVal = RST_AIN;
      IX_INTRC: rstVal = RST_INTRC;
      default: rstVal = RST_ZERO;
    endcase
  endfunction

  // Analog code to 0.1 % units, clamped at full scale
  function automatic logic [15:0] scalePct(input logic [11:0] code, input logic [11:0] zero,
                                          input logic [15:0] mul);
    logic [27:0] prod;
    prod = 28'h0;
    if (code > zero) begin
      prod = 28'({16'h0, code - zero} * mul);
    end
    if ((prod >> 12) > 28'(PCT_FULL)) begin
      scalePct = 16'(PCT_FULL);
    end else begin
      scalePct = prod[27:12];
    end
  endfunction

  // Output terminal function decode
  function automatic logic outFunc(input logic [15:0] code, input logic [4:0] st);
    logic [15:0] base;
    logic neg;
    logic v;
    base = (code >= FN_NEG) ? code - FN_NEG : code;
    neg = (code >= FN_NEG);
    v = 1'b0;
    case (base)
      FN_LOWER: v = st[ST_LOWER];
      FN_UPPER: v = st[ST_UPPER];
      FN_DIR: v = st[ST_DIR];
      FN_ACTIVE: v = st[ST_ACTIVE];
      FN_SLEEP: v = st[ST_SLEEP];
      default: neg = 1'b0;
    endcase
    outFunc = v ^ neg;
  endfunction

  logic [15:0] cfgR [0:NUM_CFG-1];
  logic ackR;
  logic [31:0] rdataR;
  pid_mode_t modeR;
  pid_mode_t modeNxt;
  logic [TW-1:0] tickCntR;
  logic signed [31:0] accR;
  logic signed [31:0] pPrevR;
  logic signed [31:0] dTermR;
  logic [9:0] msCntR;
  logic [15:0] secCntR;
  logic [15:0] freqR;
  logic outAR;
  logic outBR;

  // Bus decode; one wait cycle on every access
  wire reqAny = avs_read | avs_write;
  wire [4:0] regIx = avs_address[6:2];
  wire cfgHit = (regIx < 5'(NUM_CFG));
  wire wrDo = avs_write & ackR & cfgHit;
  assign avs_waitrequest = reqAny & ~ackR;
  assign avs_readdata = rdataR;

  // Sample tick, 1 ms
  wire tick = (tickCntR == TW'(SAMPLE_CYC - 1));

  // Settings views
  wire [15:0] actSel = cfgR[IX_ACTION];
  wire [15:0] pband = cfgR[IX_PBAND];
  wire [15:0] iTime = cfgR[IX_ITIME];
  wire [15:0] dTime = cfgR[IX_DTIME];
  wire [15:0] upLim = cfgR[IX_UPPER];
  wire [15:0] loLim = cfgR[IX_LOWER];
  wire [15:0] spSet = cfgR[IX_SETPT];
  wire [15:0] ainSel = cfgR[IX_AIN];
  wire [15:0] mRange = cfgR[IX_MRANGE];

  // Select input assigned to any input terminal
  logic selAssigned;
  always_comb begin
    selAssigned = 1'b0;
    for (int i = 0; i < NUM_INFUNC; i++) begin
      if (cfgR[int'(IX_INFUNC0) + i] == IN_PIDSEL) begin
        selAssigned = 1'b1;
      end
    end
  end

  wire codeOk = (actSel == ACT_REV) | (actSel == ACT_FWD);
  wire pidValid = codeOk & (~selAssigned | pidSelectInput);
  wire fwdSense = (actSel == ACT_FWD);

  wire t2Is5V = (ainSel == 16'h0001) | (ainSel == 16'h000b);
  wire [15:0] t2Pct = scalePct(term2Code, 12'h000, t2Is5V ? MUL_5V : MUL_10V);
  wire [15:0] t4Mul = (mRange == 16'h0000) ? MUL_4MA : (mRange == 16'h0001) ? MUL_5V : MUL_10V;
  wire [15:0] pvPct = scalePct(term4Code, (mRange == 16'h0000) ? ADC_4MA : 12'h000, t4Mul);

  wire useT2 = (spSet == CODE_OFF) & (cfgR[IX_THERM] == CODE_OFF);
  wire [15:0] spPct = useT2 ? t2Pct : ((spSet == CODE_OFF) ? 16'h0000 : spSet);

  // Deviation, set point minus measured value
  wire signed [31:0] dev = $signed({16'h0, spPct}) - $signed({16'h0, pvPct});
  wire signed [31:0] err = fwdSense ? -dev : dev;

  wire pOff = (pband == CODE_OFF) | (pband == 16'h0000);
  wire iOff = (iTime == CODE_OFF) | (iTime == 16'h0000);
  wire dOff = (dTime == CODE_OFF);

  // Proportional part, band in 0.1 %
  wire signed [31:0] pTerm = pOff ? 32'sh0 : (err * 32'sd1000) / $signed({16'h0, pband});
  // Integral step per ms, integral time in 0.1 s
  wire signed [31:0] iDiv = $signed({16'h0, iTime}) * 32'sd100;
  wire signed [31:0] iInc = iOff ? 32'sh0 : (pTerm <<< I_FRAC) / iDiv;
  wire signed [31:0] accLim = 32'(PCT_FULL) <<< I_FRAC;
  wire signed [31:0] accSum = accR + iInc;
  // Anti-windup at full scale both ways
  wire signed [31:0] accNxt = (accSum > accLim) ? accLim : (accSum < -accLim) ? -accLim : accSum;
  // Differential part, time in 0.01 s
  wire signed [31:0] dNxt = dOff ? 32'sh0
    : (pTerm - pPrevR) * $signed({16'h0, dTime}) * 32'sd10;

  wire signed [31:0] mvSum = pTerm + (accR >>> I_FRAC) + dTermR;
  wire [15:0] mvPct = (mvSum < 0) ? 16'h0000
    : (mvSum > 32'(PCT_FULL)) ? 16'(PCT_FULL) : mvSum[15:0];
  wire [31:0] pidFreqW = ({16'h0, mvPct} * 32'(FREQ_MAX)) / 32'(PCT_FULL);
  wire [15:0] pidFreq = pidFreqW[15:0];

  // Output interruption terms
  wire sleepEn = (cfgR[IX_INTRT] != CODE_OFF);
  wire lowFreq = (pidFreq < cfgR[IX_INTRL]);
  wire sleepDue = sleepEn & (secCntR >= cfgR[IX_INTRT]) & lowFreq;
  wire signed [31:0] cancelLvl = $signed({16'h0, cfgR[IX_INTRC]}) - 32'sd1000;
  wire wake = (dev >= cancelLvl);

  // Mode sequencing
  always_comb begin
    modeNxt = modeR;
    case (modeR)
      MODE_IDLE: begin
        if (pidValid) begin
          modeNxt = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (!pidValid) begin
          modeNxt = MODE_IDLE;
        end else if (sleepDue) begin
          modeNxt = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!pidValid) begin
          modeNxt = MODE_IDLE;
        end else if (!sleepEn || wake) begin
          modeNxt = MODE_RUN;
        end
      end
      default: modeNxt = MODE_IDLE;
    endcase
  end

  // Status flags
  wire pidActive = (modeR != MODE_IDLE);
  wire [4:0] status;
  assign status[ST_ACTIVE] = pidActive;
  assign status[ST_UPPER] = pidActive & (upLim != CODE_OFF) & (pvPct > upLim);
  assign status[ST_LOWER] = pidActive & (loLim != CODE_OFF) & (pvPct < loLim);
  assign status[ST_DIR] = forwardIndication & ~reverseIndication;
  assign status[ST_SLEEP] = sleepEn & (modeR == MODE_SLEEP);

  // Read data selection
  wire [31:0] rdMux = cfgHit ? {16'h0, cfgR[regIx]}
    : (regIx == IX_STATUS) ? {27'h0, status}
    : (regIx == IX_FREQ) ? {16'h0, freqR}
    : (regIx == IX_PV) ? {16'h0, pvPct} : 32'h0;

  // Bus handshake and read capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackR <= 1'b0;
      rdataR <= 32'h0;
    end else begin
      ackR <= reqAny & ~ackR;
      if (reqAny && !ackR) begin
        rdataR <= rdMux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfgR[i] <= rstVal(i);
      end
    end else if (wrDo) begin
      if (avs_byteenable[0]) begin
        cfgR[regIx][7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        cfgR[regIx][15:8] <= avs_writedata[15:8];
      end
    end
  end

  // Mode and sample timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeR <= MODE_IDLE;
      tickCntR <= '0;
    end else begin
      modeR <= modeNxt;
      tickCntR <= tick ? '0 : tickCntR + TW'(1);
    end
  end

  // Integral and differential parts restarted from zero after idle; integral held through sleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accR <= 32'sh0;
      pPrevR <= 32'sh0;
      dTermR <= 32'sh0;
    end else if (modeR != MODE_RUN) begin
      accR <= (modeR == MODE_IDLE) ? 32'sh0 : accR;
      pPrevR <= pTerm;
      dTermR <= 32'sh0;
    end else if (tick) begin
      accR <= iOff ? 32'sh0 : accNxt;
      pPrevR <= pTerm;
      dTermR <= dNxt;
    end
  end

  // Time spent below the interruption level, in seconds
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      msCntR <= 10'h0;
      secCntR <= 16'h0;
    end else if (modeR != MODE_RUN || !lowFreq || !sleepEn) begin
      msCntR <= 10'h0;
      secCntR <= 16'h0;
    end else if (tick) begin
      if (msCntR == 10'(MS_PER_S - 1)) begin
        msCntR <= 10'h0;
        // Saturate so long waits never wrap
        if (secCntR != 16'hffff) begin
          secCntR <= secCntR + 16'h0001;
        end
      end else begin
        msCntR <= msCntR + 10'h001;
      end
    end
  end

  // Frequency command and terminal drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      freqR <= 16'h0;
      outAR <= 1'b0;
      outBR <= 1'b0;
    end else begin
      case (modeR)
        MODE_RUN: freqR <= pidFreq;
        MODE_SLEEP: freqR <= 16'h0;
        default: freqR <= normalFreq;
      endcase
      outAR <= outFunc(cfgR[IX_OUTA], status);
      outBR <= outFunc(cfgR[IX_OUTB], status);
    end
  end

  assign freqCmd = freqR;
  assign termOutA = outAR;
  assign termOutB = outBR;

endmodule

// file: ppc_checker_sva.sv
// Port-level assertions for the PID process-control block
`timescale 1ns/1ps
module ppc_checker_sva
  import pid_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Drive context and terminals
  input wire logic pidSelectInput,
  input wire logic forwardIndication,
  input wire logic [15:0] normalFreq,
  input wire logic [15:0] freqCmd,
  input wire logic termOutA
);
  logic [15:0] act_r;
  logic [15:0] outA_r;
  logic [15:0] upper_r;
  logic [4:0] sel_r;
  // Decode of completed writes; full low lanes assumed
  wire [4:0] ix = avs_address[6:2];
  wire [15:0] wd = avs_writedata[15:0];
  wire wrTake = avs_write && !avs_waitrequest;
  wire selIx = ix >= IX_INFUNC0 && ix < IX_OUTA;
  wire [4:0] hit = 5'h01 << (ix - IX_INFUNC0);
  wire pidOn = (act_r == ACT_REV || act_r == ACT_FWD) && (sel_r == 5'h00 || pidSelectInput);
  // Shadow of the settings the properties depend on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= RST_ZERO;
      outA_r <= RST_ZERO;
      upper_r <= CODE_OFF;
      sel_r <= 5'h00;
    end else if (wrTake) begin
      act_r <= (ix == IX_ACTION) ? wd : act_r;
      outA_r <= (ix == IX_OUTA) ? wd : outA_r;
      upper_r <= (ix == IX_UPPER) ? wd : upper_r;
      sel_r <= selIx ? ((sel_r & ~hit) | ((wd == IN_PIDSEL) ? hit : 5'h00)) : sel_r;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && ix > IX_PV |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  normal_freq_a: assert property ((!pidOn && $stable(normalFreq))[*3] |-> freqCmd == normalFreq)
    else $error("normal command not passed through");
  active_out_a: assert property ((outA_r == FN_ACTIVE && $stable(pidOn))[*3] |-> termOutA == pidOn)
    else $error("active output wrong");
  active_neg_a: assert property ((outA_r == FN_ACTIVE + FN_NEG && $stable(pidOn))[*3] |-> termOutA != pidOn)
    else $error("inverted active output wrong");
  dir_out_a: assert property ((outA_r == FN_DIR && $stable(forwardIndication))[*3] |-> termOutA == forwardIndication)
    else $error("direction output wrong");
  upper_off_a: assert property ((outA_r == FN_UPPER && upper_r == CODE_OFF)[*3] |-> !termOutA)
    else $error("disabled upper flag asserted");
  select_gate_a: assert property (sel_r != 5'h00 && $fell(pidSelectInput) |-> ##[1:3] freqCmd == normalFreq)
    else $error("select off did not stop control");
endmodule
bind pid_process_control ppc_checker_sva u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pidSelectInput(pidSelectInput), .forwardIndication(forwardIndication),
  .normalFreq(normalFreq), .freqCmd(freqCmd), .termOutA(termOutA));

// file: ppc_src_model.sv
// Set point source and process detector feeding the ADC codes
`timescale 1ns/1ps
module ppc_src_model
  import pid_pkg::*;
(
  // Wanted levels in 0.1 %
  input wire logic [9:0] setPct,
  input wire logic [9:0] measPct,
  // Source spans
  input wire logic setHalf,
  input wire logic [1:0] measRange,
  // ADC codes, full scale is 10 V or 20 mA
  output logic [11:0] term2Code,
  output logic [11:0] term4Code
);
  wire [31:0] sp = {22'h0, setPct};
  wire [31:0] mp = {22'h0, measPct};
  wire [31:0] m4 = {20'h0, ADC_4MA} + mp * 32'hccc / 32'h3e8;
  wire [31:0] mv = mp * ((measRange == 2'h1) ? 32'h7ff : 32'hfff) / 32'h3e8;
  // set point span, 5 V or 10 V
  assign term2Code = 12'(sp * (setHalf ? 32'h7ff : 32'hfff) / 32'h3e8);
  // detector span, live zero on current loop
  assign term4Code = (measRange == 2'h0) ? m4[11:0] : mv[11:0];
endmodule

// file: testbench.sv
// Self-checking bench for the PID process-control block
`timescale 1ns/1ps
module testbench
  import pid_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] term2Code;
  logic [11:0] term4Code;
  logic pidSelectInput = 1'b0;
  logic forwardIndication = 1'b0;
  logic reverseIndication = 1'b0;
  logic [15:0] normalFreq = 16'h1234;
  logic [15:0] freqCmd;
  logic termOutA;
  logic termOutB;
  logic [9:0] setPct = 10'h000;
  logic [9:0] measPct = 10'h000;
  logic setHalf = 1'b0;
  logic [1:0] measRange = 2'h2;
  logic [31:0] rdData;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;
  // Short sample period keeps integral runs brief
  pid_process_control #(.SAMPLE_CYC(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h3), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .term2Code(term2Code),
    .term4Code(term4Code), .pidSelectInput(pidSelectInput), .forwardIndication(forwardIndication),
    .reverseIndication(reverseIndication), .normalFreq(normalFreq), .freqCmd(freqCmd),
    .termOutA(termOutA), .termOutB(termOutB));
  ppc_src_model u_src (.setPct(setPct), .measPct(measPct), .setHalf(setHalf), .measRange(measRange),
    .term2Code(term2Code), .term4Code(term4Code));
  // Clock and hang guard
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus cycle: hold until waitrequest is seen low at a rising edge, take data there
  task automatic bus(input logic r, input logic [4:0] ix, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address <= {ix, 2'b00};
    avs_writedata <= {16'h0000, d};
    avs_read <= r;
    avs_write <= !r;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rdData = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] ix, input logic [15:0] d);
    bus(1'b0, ix, d);
  endtask
  task automatic rd(input logic [4:0] ix);
    bus(1'b1, ix, 16'h0000);
  endtask
  // Settle, then look between edges
  task automatic st();
    repeat (40) @(negedge ref_clk);
  endtask
  // Rounding of the ADC path allows a small band
  task automatic pv(input logic [9:0] m, input logic [15:0] f);
    @(posedge ref_clk);
    measPct <= m;
    st();
    nTests++;
    if ($isunknown(freqCmd) || freqCmd > f + 20 || freqCmd + 20 < f) begin
      numErrors++;
      $display("unexpected at %0t: got %h exp %h", $time, freqCmd, f);
    end
  endtask
  task automatic lim(input logic [9:0] m, input logic a, input logic b);
    @(posedge ref_clk);
    measPct <= m;
    st();
    chk(termOutA, a);
    chk(termOutB, b);
  endtask
  task automatic t_regs();
    rd(IX_PBAND);
    chk(rdData, 32'h3e8);
    rd(IX_UPPER);
    chk(rdData, 32'h270f);
    wr(IX_STATUS, 16'h001f);
    rd(IX_STATUS);
    chk(rdData, 32'h0);
    rd(5'h17);
    chk(rdData, 32'h0);
    chk(freqCmd, 16'h1234);
  endtask
  task automatic t_enable();
    logic [15:0] codes [5];
    codes = '{16'h0000, 16'h0013, ACT_REV, 16'h0016, ACT_FWD};
    wr(IX_OUTA, FN_ACTIVE);
    wr(IX_OUTB, FN_ACTIVE + FN_NEG);
    foreach (codes[i]) begin
      wr(IX_ACTION, codes[i]);
      st();
      chk(termOutA, codes[i] inside {ACT_REV, ACT_FWD});
      chk(termOutB, !(codes[i] inside {ACT_REV, ACT_FWD}));
    end
  endtask
  task automatic t_select();
    wr(IX_OUTA, FN_ACTIVE + FN_NEG);
    wr(IX_INFUNC0 + 5'h02, IN_PIDSEL);
    st();
    chk(termOutA, 1'b1);
    chk(freqCmd, normalFreq);
    @(posedge ref_clk);
    pidSelectInput <= 1'b1;
    st();
    chk(termOutA, 1'b0);
    @(posedge ref_clk);
    pidSelectInput <= 1'b0;
    wr(IX_INFUNC0 + 5'h02, 16'h0000);
    st();
    chk(termOutA, 1'b0);
  endtask
  task automatic t_sense();
    wr(IX_ACTION, ACT_REV);
    pv(10'h0c8, 16'h07d0);
    pv(10'h320, 16'h0000);
    wr(IX_ACTION, ACT_FWD);
    pv(10'h0c8, 16'h0000);
    pv(10'h320, 16'h03e8);
    // Integral joins the proportional part; a quarter of its time adds a quarter of P
    wr(IX_ITIME, 16'h000a);
    rd(IX_ITIME);
    chk(rdData, 32'h000a);
    repeat (2000) @(negedge ref_clk);
    chk(freqCmd > 16'h0440, 1'b1);
    wr(IX_ITIME, CODE_OFF);
    wr(IX_ACTION, 16'h0000);
  endtask
  task automatic t_source();
    wr(IX_ACTION, ACT_REV);
    wr(IX_SETPT, CODE_OFF);
    @(posedge ref_clk);
    setPct <= 10'h258;
    pv(10'h0c8, 16'h07d0);
    @(posedge ref_clk);
    setHalf <= 1'b1;
    wr(IX_AIN, 16'h000b);
    pv(10'h0c8, 16'h07d0);
    wr(IX_THERM, 16'h0064);
    pv(10'h0c8, 16'h0000);
    wr(IX_THERM, CODE_OFF);
    wr(IX_SETPT, 16'h0258);
    for (int r = 0; r < 3; r++) begin
      @(posedge ref_clk);
      measRange <= 2'(r);
      wr(IX_MRANGE, 16'(r));
      pv(10'h0c8, 16'h07d0);
    end
  endtask
  task automatic t_limits();
    wr(IX_OUTA, FN_UPPER);
    wr(IX_OUTB, FN_LOWER);
    wr(IX_UPPER, 16'h01f4);
    wr(IX_LOWER, 16'h0064);
    lim(10'h258, 1'b1, 1'b0);
    lim(10'h032, 1'b0, 1'b1);
    lim(10'h12c, 1'b0, 1'b0);
    wr(IX_UPPER, CODE_OFF);
    wr(IX_LOWER, CODE_OFF);
    lim(10'h2bc, 1'b0, 1'b0);
    lim(10'h032, 1'b0, 1'b0);
  endtask
  // Output interruption after one second below the level, then wake on deviation
  task automatic t_sleep();
    wr(IX_OUTA, FN_SLEEP);
    pv(10'h320, 16'h0000);
    wr(IX_INTRL, 16'h0064);
    wr(IX_INTRT, 16'h0001);
    repeat (7800) @(negedge ref_clk);
    chk(termOutA, 1'b0);
    repeat (300) @(negedge ref_clk);
    chk(termOutA, 1'b1);
    chk(freqCmd, 16'h0000);
    pv(10'h0c8, 16'h07d0);
    chk(termOutA, 1'b0);
    wr(IX_INTRT, CODE_OFF);
  endtask
  task automatic t_dir();
    wr(IX_OUTA, FN_DIR);
    wr(IX_OUTB, FN_DIR + FN_NEG);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      forwardIndication <= (k == 0);
      reverseIndication <= (k == 1);
      st();
      chk(termOutA, k == 0);
      chk(termOutB, k != 0);
    end
  endtask
  // Reset, register checks, common settings, then the other scenarios
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    wr(IX_ITIME, CODE_OFF);
    wr(IX_AIN, 16'h0000);
    wr(IX_MRANGE, 16'h0002);
    wr(IX_SETPT, 16'h0258);
    t_enable();
    t_select();
    t_sense();
    t_source();
    t_limits();
    t_sleep();
    t_dir();
    tally_and_finish();
  end
endmodule
